//--- rtl/focr_pkg.sv
// Purpose: Constants and types for the fan and overtemperature configuration registers.
// Assumes: 8-bit register port behind a serial management bus decoder.
// Notes: Offsets are byte addresses of the management register space.
package focr_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] FOCR_PULSE_OFS = 8'h7B;
  localparam logic [7:0] FOCR_FMT_OFS = 8'h7C;
  localparam logic [7:0] FOCR_PIN_OFS = 8'h7D;
  localparam logic [7:0] FOCR_FANMAX1_OFS = 8'h38;
  localparam logic [7:0] FOCR_FANMAX3_OFS = 8'h3A;
  // ==========================================================
  // Reset values
  localparam logic [7:0] FOCR_PULSE_RST = 8'h55;
  localparam logic [7:0] FOCR_FMT_RST = 8'h00;
  localparam logic [7:0] FOCR_PIN_RST = 8'h00;
  // ==========================================================
  // Field positions
  localparam int FOCR_SIGNED_BIT = 0;
  localparam int FOCR_OFSRANGE_BIT = 1;
  localparam int FOCR_GPIODIR_BIT = 2;
  localparam int FOCR_GPIOPOL_BIT = 3;
  localparam int FOCR_HYST_BIT = 4;
  localparam int FOCR_R1EN_BIT = 5;
  localparam int FOCR_LOCEN_BIT = 6;
  localparam int FOCR_R2EN_BIT = 7;
  localparam int FOCR_OTDIS_BIT = 2;
  localparam int FOCR_FANLVL_BIT = 3;
  localparam int FOCR_CHSEL_BIT = 4;
  localparam int FOCR_BYPASS_BIT = 5;
  localparam logic [7:0] FOCR_PIN_MASK = 8'h3F;
  localparam logic [7:0] FOCR_MIN_EXCESS64 = 8'h00;
  localparam logic [7:0] FOCR_MIN_TWOS = 8'h80;
  // ==========================================================
  // Shared pin roles
  typedef enum logic [1:0] {
    FOCR_PIN_TACH = 2'h0,
    FOCR_PIN_OVERTEMP = 2'h1,
    FOCR_PIN_ALERT = 2'h2,
    FOCR_PIN_GPIO = 2'h3
  } focr_pin_role_type;
  // Register access request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } focr_req_type;
  // Decoded configuration
  typedef struct packed {
    logic [2:0] first_fan_pulse_sel;
    logic [2:0] second_fan_pulse_sel;
    logic [2:0] third_fan_pulse_sel;
    logic [2:0] fourth_fan_pulse_sel;
    logic signed_temp_format;
    logic offset_range_wide;
    logic gpio_is_output;
    logic gpio_active_high;
    logic overtemp_hysteresis_en;
    logic remote1_overtemp_limit_en;
    logic local_overtemp_limit_en;
    logic remote2_overtemp_limit_en;
    focr_pin_role_type shared_pin_function;
    logic overtemp_output_disable;
    logic overtemp_fan_level_sel;
    logic overtemp_channel_sel;
    logic supply_attenuator_bypass;
  } focr_cfg_type;
endpackage : focr_pkg

//--- rtl/focr_config_regs.sv
// Purpose: Pulse-count, format/GPIO/overtemp and pin-function configuration registers.
// Assumes: Register port from the management bus decoder, same clock, one access per cycle.
// Notes: Lock input comes from the lock register elsewhere; it only clears on reset.

module focr_config_regs
  import focr_pkg::*;
#(
  parameter bit LATCH_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic req_valid_i,
  input wire focr_req_type req_i,
  output logic [7:0] rdata_o,
  output logic hit_o,
  // Lock and system controls from other registers
  input wire logic global_lock_i,
  input wire logic overtemp_enable_i,
  // Overtemp limits and measurement state
  input wire logic [7:0] remote1_limit_i,
  input wire logic [7:0] local_limit_i,
  input wire logic [7:0] remote2_limit_i,
  input wire logic [2:0] channel_over_i,
  // Shared pin sampled from outside
  input wire logic shared_pin_in_i,
  // Decoded configuration
  output focr_cfg_type cfg_o,
  output logic [2:0] channel_active_o,
  output logic overtemp_pin_active_o,
  output logic overtemp_assert_o,
  output logic fan_full_speed_o,
  output logic fan_use_max_regs_o,
  output logic [7:0] fan_max_first_ofs_o,
  output logic [7:0] fan_max_last_ofs_o,
  // Shared pin drive: output enable low while driving
  output logic shared_pin_out_o,
  output logic shared_pin_oe_b_o,
  output logic gpio_in_o
);

  // ==========================================================
  // Registers
  logic [7:0] pulse_r;
  logic [7:0] fmt_r;
  logic [7:0] pin_r;
  logic [7:0] fmt_mask;
  logic wr_ok;
  logic pin_meta_r;
  logic pin_sync_r;
  logic gpio_out_level_r;

  // Hysteresis bit only exists on the latch variant
  // variant masking
  assign fmt_mask = LATCH_VARIANT ? 8'hFF : 8'hEF;

  assign wr_ok = req_valid_i && req_i.wr && !global_lock_i;

  function automatic logic [2:0] pulses_of(input logic [1:0] code);
    pulses_of = {1'b0, code} + 3'h1;
  endfunction : pulses_of

  function automatic logic is_min_limit(input logic [7:0] lim, input logic twos);
    is_min_limit = twos ? (lim == FOCR_MIN_TWOS) : (lim == FOCR_MIN_EXCESS64);
  endfunction : is_min_limit

  // ==========================================================
  // Write paths
  // pulse fields stored
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_r <= FOCR_PULSE_RST;
    end else if (wr_ok && req_i.addr == FOCR_PULSE_OFS) begin
      pulse_r <= req_i.wdata;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fmt_r <= FOCR_FMT_RST;
    end else if (wr_ok && req_i.addr == FOCR_FMT_OFS) begin
      fmt_r <= req_i.wdata & fmt_mask;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_r <= FOCR_PIN_RST;
    end else if (wr_ok && req_i.addr == FOCR_PIN_OFS) begin
      pin_r <= req_i.wdata & FOCR_PIN_MASK & (LATCH_VARIANT ? 8'hFF : 8'hEF);
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    hit_o = 1'b1;
    case (req_i.addr)
      FOCR_PULSE_OFS: rdata_o = pulse_r;
      FOCR_FMT_OFS: rdata_o = fmt_r;
      FOCR_PIN_OFS: rdata_o = pin_r;
      default: begin
        rdata_o = 8'h00;
        hit_o = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Decoded configuration
  always_comb begin
    cfg_o.first_fan_pulse_sel = pulses_of(pulse_r[1:0]);
    cfg_o.second_fan_pulse_sel = pulses_of(pulse_r[3:2]);
    cfg_o.third_fan_pulse_sel = pulses_of(pulse_r[5:4]);
    cfg_o.fourth_fan_pulse_sel = pulses_of(pulse_r[7:6]);
    cfg_o.signed_temp_format = fmt_r[FOCR_SIGNED_BIT];
    cfg_o.offset_range_wide = fmt_r[FOCR_OFSRANGE_BIT];
    cfg_o.gpio_is_output = fmt_r[FOCR_GPIODIR_BIT];
    cfg_o.gpio_active_high = fmt_r[FOCR_GPIOPOL_BIT];
    cfg_o.overtemp_hysteresis_en = fmt_r[FOCR_HYST_BIT];
    cfg_o.remote1_overtemp_limit_en = fmt_r[FOCR_R1EN_BIT];
    cfg_o.local_overtemp_limit_en = fmt_r[FOCR_LOCEN_BIT];
    cfg_o.remote2_overtemp_limit_en = fmt_r[FOCR_R2EN_BIT];
    cfg_o.shared_pin_function = focr_pin_role_type'(pin_r[1:0]);
    cfg_o.overtemp_output_disable = pin_r[FOCR_OTDIS_BIT];
    cfg_o.overtemp_fan_level_sel = pin_r[FOCR_FANLVL_BIT];
    cfg_o.overtemp_channel_sel = pin_r[FOCR_CHSEL_BIT];
    cfg_o.supply_attenuator_bypass = pin_r[FOCR_BYPASS_BIT];
  end

  // ==========================================================
  // Overtemp channel qualification
  // minimum limit disables
  always_comb begin
    channel_active_o[0] = fmt_r[FOCR_R1EN_BIT] && !is_min_limit(remote1_limit_i, fmt_r[FOCR_SIGNED_BIT]);
    channel_active_o[1] = fmt_r[FOCR_LOCEN_BIT] && !is_min_limit(local_limit_i, fmt_r[FOCR_SIGNED_BIT]);
    channel_active_o[2] = fmt_r[FOCR_R2EN_BIT] && !is_min_limit(remote2_limit_i, fmt_r[FOCR_SIGNED_BIT]);
    if (LATCH_VARIANT && !pin_r[FOCR_CHSEL_BIT]) begin
      channel_active_o[0] = 1'b0;
    end
  end

  assign overtemp_pin_active_o = overtemp_enable_i && (pin_r[1:0] == FOCR_PIN_OVERTEMP);

  assign overtemp_assert_o = overtemp_pin_active_o && !pin_r[FOCR_OTDIS_BIT]
                             && |(channel_active_o & channel_over_i);

  assign fan_full_speed_o = overtemp_assert_o && !pin_r[FOCR_FANLVL_BIT];
  assign fan_use_max_regs_o = overtemp_assert_o && pin_r[FOCR_FANLVL_BIT];
  assign fan_max_first_ofs_o = FOCR_FANMAX1_OFS;
  assign fan_max_last_ofs_o = FOCR_FANMAX3_OFS;

  // ==========================================================
  // Shared pin: synchroniser, GPIO drive and overtemp drive
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= shared_pin_in_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  assign gpio_in_o = pin_sync_r;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gpio_out_level_r <= 1'b0;
    end else begin
      gpio_out_level_r <= fmt_r[FOCR_GPIOPOL_BIT];
    end
  end

  always_comb begin
    shared_pin_out_o = 1'b1;
    shared_pin_oe_b_o = 1'b1;
    if (pin_r[1:0] == FOCR_PIN_GPIO && fmt_r[FOCR_GPIODIR_BIT]) begin
      shared_pin_out_o = gpio_out_level_r;
      shared_pin_oe_b_o = 1'b0;
    end else if (overtemp_assert_o) begin
      // Open-drain active-low overtemp pulls low
      shared_pin_out_o = 1'b0;
      shared_pin_oe_b_o = 1'b0;
    end
  end

  // ==========================================================
  // Checks
  // Properties are off while reset is low, so the async clear never trips them
  // lock blocks writes
  lock_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    global_lock_i |=> $stable(pulse_r) && $stable(fmt_r) && $stable(pin_r))
    else $error("configuration changed while locked");

  rsvd_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    pin_r[7:6] == 2'h0) else $error("reserved pin-function bits set");

  ot_disable_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    pin_r[FOCR_OTDIS_BIT] |-> !overtemp_assert_o) else $error("overtemp asserted while disabled");

  ot_role_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    overtemp_assert_o |-> overtemp_enable_i && pin_r[1:0] == FOCR_PIN_OVERTEMP)
    else $error("overtemp without role");

  min_limit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    fmt_r[FOCR_SIGNED_BIT] && remote1_limit_i == FOCR_MIN_TWOS |-> !channel_active_o[0])
    else $error("min limit channel active");

  min_local_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !fmt_r[FOCR_SIGNED_BIT] && local_limit_i == FOCR_MIN_EXCESS64 |-> !channel_active_o[1])
    else $error("min local limit channel active");

  pulse_wr_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    wr_ok && req_i.addr == FOCR_PULSE_OFS |=> pulse_r == $past(req_i.wdata))
    else $error("pulse write lost");

  fan_level_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    overtemp_assert_o |-> fan_full_speed_o != pin_r[FOCR_FANLVL_BIT]) else $error("wrong fan level");

  pulse_dec_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    pulse_r[1:0] == 2'h1 |-> cfg_o.first_fan_pulse_sel == 3'h2) else $error("pulse decode wrong");

  gpio_dir_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    pin_r[1:0] == FOCR_PIN_GPIO && !fmt_r[FOCR_GPIODIR_BIT] && !overtemp_assert_o |-> shared_pin_oe_b_o)
    else $error("input driven");

  chan_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    LATCH_VARIANT && !pin_r[FOCR_CHSEL_BIT] |-> !channel_active_o[0])
    else $error("remote1 counted without channel select");

  hyst_rsvd_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !LATCH_VARIANT |-> !fmt_r[FOCR_HYST_BIT] && !pin_r[FOCR_CHSEL_BIT])
    else $error("variant-only bit set on base variant");

  // Pin configured as a GPIO output
  sequence gpio_out_sel_s;
    pin_r[1:0] == FOCR_PIN_GPIO && fmt_r[FOCR_GPIODIR_BIT];
  endsequence

  gpio_drive_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    gpio_out_sel_s |-> !shared_pin_oe_b_o)
    else $error("GPIO output not driven");

  // level follows polarity
  // The level is registered, so it trails a polarity change by one cycle
  gpio_pol_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    gpio_out_sel_s ##1 gpio_out_sel_s |-> shared_pin_out_o == $past(fmt_r[FOCR_GPIOPOL_BIT]))
    else $error("GPIO level does not follow polarity");

  // Every condition for an overtemp output in one cycle
  sequence ot_cause_s;
    overtemp_enable_i && pin_r[1:0] == FOCR_PIN_OVERTEMP && !pin_r[FOCR_OTDIS_BIT]
    && |(channel_active_o & channel_over_i);
  endsequence

  ot_drive_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    ot_cause_s |-> overtemp_assert_o && !shared_pin_oe_b_o && !shared_pin_out_o)
    else $error("overtemp not driven on pin");

  fan_max_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    ot_cause_s |-> fan_use_max_regs_o == pin_r[FOCR_FANLVL_BIT] && fan_full_speed_o != pin_r[FOCR_FANLVL_BIT])
    else $error("fan level select ignored");

endmodule : focr_config_regs

//--- verif/focr_host_model.sv
// Purpose: Host side of the register port, issuing single-byte accesses.
// Assumes: The block samples requests on the rising edge.
// Notes: Requests are set at the falling edge and held over one rising edge.
module focr_host_model
  import focr_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Register port
  input wire logic [7:0] rdata_i,
  output logic req_valid_o,
  output focr_req_type req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end

  // ==========================================================
  // Access task
  // host orders config before lock
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    @(negedge sys_clk_i);
    req_valid_o = 1'b1;
    req_o = '{wr: wr, addr: addr, wdata: wdata};
    @(posedge sys_clk_i);
    rdata = rdata_i;
    @(negedge sys_clk_i);
    req_valid_o = 1'b0;
    // Stale data is not left on the bus
    req_o.wdata = ~wdata;
  endtask : access
endmodule : focr_host_model

//--- verif/focr_config_regs_tb_top.sv
// Purpose: Self-checking bench for the fan and overtemperature configuration registers.
// Assumes: Base variant plus a latch-variant twin on the same inputs, driven at the falling edge.
// Notes: Overtemp output timing is waited for under a bound.
module focr_config_regs_tb_top
  import focr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, rst_b_i, req_valid_i, global_lock_i, overtemp_enable_i, shared_pin_in_i;
  logic hit_o, overtemp_pin_active_o, overtemp_assert_o, fan_full_speed_o, fan_use_max_regs_o;
  logic shared_pin_out_o, shared_pin_oe_b_o, gpio_in_o;
  logic [7:0] rdata_o, remote1_limit_i, local_limit_i, remote2_limit_i, fan_max_first_ofs_o, fan_max_last_ofs_o;
  logic [2:0] channel_over_i, channel_active_o;
  focr_req_type req_i;
  focr_cfg_type cfg_o;
  logic [7:0] rdata_lv;
  logic [2:0] channel_active_lv;
  int err_total, checks;

  focr_config_regs focr_config_regs_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .rdata_o(rdata_o), .hit_o(hit_o),
    .global_lock_i(global_lock_i), .overtemp_enable_i(overtemp_enable_i),
    .remote1_limit_i(remote1_limit_i), .local_limit_i(local_limit_i), .remote2_limit_i(remote2_limit_i),
    .channel_over_i(channel_over_i), .shared_pin_in_i(shared_pin_in_i), .cfg_o(cfg_o),
    .channel_active_o(channel_active_o), .overtemp_pin_active_o(overtemp_pin_active_o),
    .overtemp_assert_o(overtemp_assert_o), .fan_full_speed_o(fan_full_speed_o),
    .fan_use_max_regs_o(fan_use_max_regs_o), .fan_max_first_ofs_o(fan_max_first_ofs_o),
    .fan_max_last_ofs_o(fan_max_last_ofs_o), .shared_pin_out_o(shared_pin_out_o),
    .shared_pin_oe_b_o(shared_pin_oe_b_o), .gpio_in_o(gpio_in_o));
  focr_host_model focr_host_model_i (.sys_clk_i(sys_clk_i), .rdata_i(rdata_o),
    .req_valid_o(req_valid_i), .req_o(req_i));
  // Latch-variant twin sees every access, so its extra bits are read back alongside
  focr_config_regs #(.LATCH_VARIANT(1'b1)) focr_config_regs_lv_i (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_i(req_i), .rdata_o(rdata_lv), .hit_o(),
    .global_lock_i(global_lock_i), .overtemp_enable_i(overtemp_enable_i),
    .remote1_limit_i(remote1_limit_i), .local_limit_i(local_limit_i), .remote2_limit_i(remote2_limit_i),
    .channel_over_i(channel_over_i), .shared_pin_in_i(shared_pin_in_i), .cfg_o(),
    .channel_active_o(channel_active_lv), .overtemp_pin_active_o(), .overtemp_assert_o(),
    .fan_full_speed_o(), .fan_use_max_regs_o(), .fan_max_first_ofs_o(), .fan_max_last_ofs_o(),
    .shared_pin_out_o(), .shared_pin_oe_b_o(), .gpio_in_o());

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    focr_host_model_i.access(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] r;
    focr_host_model_i.access(1'b0, a, 8'h00, r);
    chk(what, r, exp);
  endtask : rd
  task automatic final_report();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task automatic wait_ot(input logic lvl);
    int n;
    n = 0;
    while (overtemp_assert_o !== lvl && n < 8) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("ot_assert", {7'h00, overtemp_assert_o}, {7'h00, lvl});
    if (overtemp_assert_o !== lvl) begin
      final_report();
    end
  endtask : wait_ot
  task automatic reset_dut();
    rst_b_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    global_lock_i = 1'b0;
    rst_b_i = 1'b1;
  endtask : reset_dut

  // ==========================================================
  // Sequence
  initial begin
    logic [7:0] k;
    err_total = 0;
    checks = 0;
    rst_b_i = 1'b0;
    global_lock_i = 1'b0;
    overtemp_enable_i = 1'b1;
    shared_pin_in_i = 1'b0;
    remote1_limit_i = 8'h80;
    local_limit_i = 8'h00;
    remote2_limit_i = 8'h50;
    channel_over_i = 3'h7;
    reset_dut();
    rd(FOCR_PULSE_OFS, 8'h55, "pulse_rst");
    chk("first_fan_pulse_sel_rst", {5'h00, cfg_o.first_fan_pulse_sel}, 8'h02);
    rd(FOCR_FMT_OFS, 8'h00, "fmt_rst");
    rd(FOCR_PIN_OFS, 8'h00, "pin_rst");
    chk("oe_b_rst", {7'h00, shared_pin_oe_b_o}, 8'h01);
    wr(FOCR_PULSE_OFS, 8'h1B);
    rd(FOCR_PULSE_OFS, 8'h1B, "pulse_rw");
    chk("first_fan_pulse_sel", {5'h00, cfg_o.first_fan_pulse_sel}, 8'h04);
    chk("second_fan_pulse_sel", {5'h00, cfg_o.second_fan_pulse_sel}, 8'h03);
    chk("third_fan_pulse_sel", {5'h00, cfg_o.third_fan_pulse_sel}, 8'h02);
    chk("fourth_fan_pulse_sel", {5'h00, cfg_o.fourth_fan_pulse_sel}, 8'h01);
    wr(FOCR_FMT_OFS, 8'hFF);
    rd(FOCR_FMT_OFS, 8'hEF, "fmt_rw");
    chk("fmt_latch", rdata_lv, 8'hFF);
    chk("fmt_cfg", {cfg_o.remote2_overtemp_limit_en, cfg_o.local_overtemp_limit_en,
      cfg_o.remote1_overtemp_limit_en, cfg_o.overtemp_hysteresis_en, cfg_o.gpio_active_high,
      cfg_o.gpio_is_output, cfg_o.offset_range_wide, cfg_o.signed_temp_format}, 8'hEF);
    chk("ch_twos", {5'h00, channel_active_o}, 8'h06);
    wr(FOCR_FMT_OFS, 8'hE0);
    chk("ch_ex64", {5'h00, channel_active_o}, 8'h05);
    wr(FOCR_PIN_OFS, 8'hFF);
    rd(FOCR_PIN_OFS, 8'h2F, "pin_rw");
    chk("pin_latch", rdata_lv, 8'h3F);
    chk("ch_both", {5'h00, channel_active_lv}, 8'h05);
    chk("pin_cfg", {2'b00, cfg_o.supply_attenuator_bypass, cfg_o.overtemp_channel_sel,
      cfg_o.overtemp_fan_level_sel, cfg_o.overtemp_output_disable, cfg_o.shared_pin_function}, 8'h2F);
    // GPIO role: no overtemp output, so neither fan level is forced
    chk("fan_lvl", {6'h00, fan_full_speed_o, fan_use_max_regs_o}, 8'h00);
    chk("max_first", fan_max_first_ofs_o, 8'h38);
    chk("max_last", fan_max_last_ofs_o, 8'h3A);
    for (k = 8'h00; k < 8'h04; k++) begin
      wr(FOCR_PIN_OFS, k);
      chk("role", {6'h00, cfg_o.shared_pin_function}, k);
      chk("pin_act", {7'h00, overtemp_pin_active_o}, {7'h00, k == 8'h01});
    end
    wr(FOCR_PIN_OFS, 8'h01);
    chk("ch_latch", {5'h00, channel_active_lv}, 8'h04);
    overtemp_enable_i = 1'b0;
    @(negedge sys_clk_i);
    chk("pin_off", {7'h00, overtemp_pin_active_o}, 8'h00);
    overtemp_enable_i = 1'b1;
    wait_ot(1'b1);
    @(negedge sys_clk_i);
    chk("ot_drive", {6'h00, shared_pin_oe_b_o, shared_pin_out_o}, 8'h00);
    chk("fan_full", {6'h00, fan_full_speed_o, fan_use_max_regs_o}, 8'h02);
    wr(FOCR_PIN_OFS, 8'h09);
    chk("fan_max", {6'h00, fan_full_speed_o, fan_use_max_regs_o}, 8'h01);
    wr(FOCR_PIN_OFS, 8'h05);
    wait_ot(1'b0);
    wr(FOCR_PIN_OFS, 8'h03);
    wr(FOCR_FMT_OFS, 8'h00);
    shared_pin_in_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk("gpio_in", {7'h00, gpio_in_o}, 8'h01);
    chk("gpio_oe_b", {7'h00, shared_pin_oe_b_o}, 8'h01);
    wr(FOCR_FMT_OFS, 8'h0C);
    @(negedge sys_clk_i);
    chk("gpio_hi", {6'h00, shared_pin_oe_b_o, shared_pin_out_o}, 8'h01);
    wr(FOCR_FMT_OFS, 8'h04);
    @(negedge sys_clk_i);
    chk("gpio_lo", {6'h00, shared_pin_oe_b_o, shared_pin_out_o}, 8'h00);
    global_lock_i = 1'b1;
    wr(FOCR_PULSE_OFS, 8'h00);
    rd(FOCR_PULSE_OFS, 8'h1B, "lock_pulse");
    wr(FOCR_FMT_OFS, 8'hFF);
    rd(FOCR_FMT_OFS, 8'h04, "lock_fmt");
    wr(FOCR_PIN_OFS, 8'h00);
    rd(FOCR_PIN_OFS, 8'h03, "lock_pin");
    chk("hit_map", {7'h00, hit_o}, 8'h01);
    wr(8'h7E, 8'hA5);
    rd(8'h7E, 8'h00, "unmapped");
    chk("hit", {7'h00, hit_o}, 8'h00);
    reset_dut();
    rd(FOCR_PULSE_OFS, 8'h55, "pulse_rst2");
    final_report();
  end
endmodule : focr_config_regs_tb_top
